//--- verilog/drwg_top.sv
/*
 * Debug register file with write guard: debugger on APB, monitor program
 * on a move port; also the status force, the break filter and the
 * optimisation disables.
 * Assumes one 100 MHz clock and synchronous CPU status inputs.
 */
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/10ps
// Function
// - Debugger writes anything when disabled or halted
// - Reads: debugger always, CPU when privileged
// - Protect setting limits CPU to two registers
// - Refused writes vanish silently, no error
// - Control, trigger, ident, mailboxes writable by both
// - Memory access registers: debugger only while running
// - Trace control: debugger toggles enables only
// - Trace addresses: debugger only when channel off
// - Break control: debugger enables only; CPU needs status
// - Break address/data/pair: unit off, or CPU with status
// - Optimisation, debug insn, debug PC locked
// - Move instructions transfer word by index
// - Bytecode debug entry forces RISC exception context
// - No break on stack increment; step skips
// - Auto-disable optimisations unless mask bit set
// - Override mask holds until written or reset
// - Trace disables branch prediction unless overridden
// - Debug enable disables folding unless overridden
module drwg_top
    import drwg_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // APB slave, debugger side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [drwg_pkg::ADDR_W-1:0] paddr,
    input wire logic [drwg_pkg::DATA_W-1:0] pwdata,
    output logic [drwg_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Move-to/move-from port, monitor side
    input wire logic cpu_req_i,
    input wire logic cpu_we_i,
    input wire logic [drwg_pkg::IDX_W-1:0] cpu_idx_i,
    input wire logic [drwg_pkg::DATA_W-1:0] cpu_wdata_i,
    output logic cpu_ack_o,
    output logic [drwg_pkg::DATA_W-1:0] cpu_rdata_o,
    // CPU state
    input wire logic cpu_halted_i,
    input wire logic cpu_privileged_i,
    input wire logic [drwg_pkg::MODE_W-1:0] cpu_exec_mode_i,
    input wire logic debug_mode_status_bit_i,
    input wire logic bytecode_mode_bit_i,
    // Debug entry and status register override
    input wire logic debug_entry_i,
    output logic sr_force_o,
    output logic debug_state_bit_o,
    output logic bytecode_mode_bit_o,
    output logic [drwg_pkg::MODE_W-1:0] exec_mode_field_o,
    // Breakpoint and single step
    input wire logic bp_hit_raw_i,
    input wire logic bp_insn_is_stack_inc_i,
    input wire logic step_req_i,
    input wire logic retire_i,
    input wire logic retire_is_stack_inc_i,
    output logic bp_trigger_o,
    output logic step_halt_o,
    // Optimisation disables
    output logic [drwg_pkg::OPT_W-1:0] cpu_optim_control_o
);
    logic [DATA_W-1:0] regs_ff [NREG];
    logic [DATA_W-1:0] prdata_ff;
    logic pready_ff;
    logic cpu_ack_ff;
    logic [DATA_W-1:0] cpu_rdata_ff;
    logic sr_force_ff;
    logic bp_trigger_ff;
    logic step_pending_ff;
    logic step_halt_ff;

    logic [IDX_W-1:0] dbg_idx;
    logic dbg_mapped;
    logic dbg_wr;
    logic cpu_wr;
    logic dbg_allow;
    logic dbg_en_only;
    logic cpu_allow;
    logic cpu_en_only;
    logic ocd_en;
    logic ptrace_en;
    logic prot_ok;
    logic [1:0] trace_ch_en;
    logic pc_bp_en;
    logic data_bp_en;
    logic [1:0] prot_sel;
    logic cpu_can_read;
    logic [DATA_W-1:0] dbg_read_word;
    logic [DATA_W-1:0] cpu_read_word;
    logic nxt_step_pending;
    logic nxt_step_halt;

    function automatic logic [DATA_W-1:0] enable_mask(input logic [IDX_W-1:0] idx);
        enable_mask = (idx == IDX_TRACE_CTRL) ? TRACE_EN_MASK : BW_EN_MASK;
    endfunction

    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                               input logic [DATA_W-1:0] new_v,
                                               input logic en_only,
                                               input logic [IDX_W-1:0] idx);
        logic [DATA_W-1:0] m;
        m = en_only ? enable_mask(idx) : {DATA_W{1'b1}};
        merge = (old_v & ~m) | (new_v & m);
    endfunction

    // Word index; anything past the register file is unmapped
    assign dbg_idx = paddr[IDX_W+1:2];
    assign dbg_mapped = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:IDX_W+2] == '0) &&
                        (dbg_idx < IDX_W'(NREG));
    assign dbg_wr = psel && penable && pready_ff && pwrite && dbg_mapped;
    assign cpu_wr = cpu_req_i && cpu_we_i && cpu_privileged_i;

    // State taken from the register file
    assign ocd_en = regs_ff[IDX_DEV_CTRL][DC_OCD_EN];
    assign ptrace_en = regs_ff[IDX_DEV_CTRL][DC_PTRACE_EN];
    assign prot_sel = regs_ff[IDX_DEV_CTRL][DC_PROT_LO +: DC_PROT_W];
    assign prot_ok = (prot_sel == PROT_ALL_PRIV) ||
                     ((prot_sel == PROT_EXC_ONLY) && (cpu_exec_mode_i == MODE_EXCEPTION));
    assign trace_ch_en = regs_ff[IDX_TRACE_CTRL][1:0];
    assign pc_bp_en = |(regs_ff[IDX_BW_CTRL_PC] & BW_EN_MASK);
    assign data_bp_en = |(regs_ff[IDX_BW_CTRL_DATA] & BW_EN_MASK);

    drwg_permit u_dbg_permit (
        .idx_i(dbg_idx),
        .from_dbg_i(1'b1),
        .ocd_en_i(ocd_en),
        .halted_i(cpu_halted_i),
        .dm_bit_i(debug_mode_status_bit_i),
        .prot_ok_i(prot_ok),
        .trace_ch_en_i(trace_ch_en),
        .pc_bp_en_i(pc_bp_en),
        .data_bp_en_i(data_bp_en),
        .allow_o(dbg_allow),
        .en_only_o(dbg_en_only)
    );

    drwg_permit u_cpu_permit (
        .idx_i(cpu_idx_i),
        .from_dbg_i(1'b0),
        .ocd_en_i(ocd_en),
        .halted_i(cpu_halted_i),
        .dm_bit_i(debug_mode_status_bit_i),
        .prot_ok_i(prot_ok),
        .trace_ch_en_i(trace_ch_en),
        .pc_bp_en_i(pc_bp_en),
        .data_bp_en_i(data_bp_en),
        .allow_o(cpu_allow),
        .en_only_o(cpu_en_only)
    );

    // Register storage; refused writes simply leave the word alone
    generate
        for (genvar i = 0; i < NREG; i++) begin : g_reg
            logic dbg_hit;
            logic cpu_hit;
            logic [DATA_W-1:0] nxt_reg;
            assign dbg_hit = dbg_wr && dbg_allow && (dbg_idx == IDX_W'(i));
            assign cpu_hit = cpu_wr && cpu_allow && (cpu_idx_i == IDX_W'(i)) && !dbg_hit;
            assign nxt_reg = dbg_hit ? merge(regs_ff[i], pwdata, dbg_en_only, IDX_W'(i)) :
                             cpu_hit ? merge(regs_ff[i], cpu_wdata_i, cpu_en_only, IDX_W'(i)) :
                             regs_ff[i];
            // Mask changes only here, so it holds until written or reset
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    regs_ff[i] <= REG_RESET;
                end else begin
                    regs_ff[i] <= nxt_reg;
                end
            end
        end
    endgenerate

    // Read paths
    assign dbg_read_word = dbg_mapped ? regs_ff[dbg_idx] : '0;
    assign cpu_can_read = cpu_privileged_i && (cpu_idx_i < IDX_W'(NREG));
    assign cpu_read_word = cpu_can_read ? regs_ff[cpu_idx_i] : '0;

    // APB: one wait-free access phase; pready is high in the access cycle after setup
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_ff <= 1'b0;
            prdata_ff <= '0;
        end else begin
            pready_ff <= psel && !penable;
            prdata_ff <= (psel && !penable && !pwrite) ? dbg_read_word : prdata_ff;
        end
    end

    // Move instructions: answered the cycle after the request
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cpu_ack_ff <= 1'b0;
            cpu_rdata_ff <= '0;
        end else begin
            cpu_ack_ff <= cpu_req_i;
            cpu_rdata_ff <= (cpu_req_i && !cpu_we_i) ? cpu_read_word : cpu_rdata_ff;
        end
    end

    // Debug entry from bytecode mode forces RISC exception context
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sr_force_ff <= 1'b0;
        end else begin
            sr_force_ff <= debug_entry_i && bytecode_mode_bit_i;
        end
    end

    // Stepping over the stack increment also runs the next instruction
    always_comb begin
        nxt_step_pending = step_pending_ff;
        nxt_step_halt = 1'b0;
        if (step_req_i) begin
            nxt_step_pending = 1'b1;
        end else if (step_pending_ff && retire_i && !retire_is_stack_inc_i) begin
            nxt_step_pending = 1'b0;
            nxt_step_halt = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bp_trigger_ff <= 1'b0;
            step_pending_ff <= 1'b0;
            step_halt_ff <= 1'b0;
        end else begin
            bp_trigger_ff <= bp_hit_raw_i && !bp_insn_is_stack_inc_i;
            step_pending_ff <= nxt_step_pending;
            step_halt_ff <= nxt_step_halt;
        end
    end

    drwg_optim u_optim (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ocd_en_i(ocd_en),
        .ptrace_en_i(ptrace_en),
        .data_bp_en_i(data_bp_en),
        .mask_i(regs_ff[IDX_OVERRIDE_MASK][OPT_W-1:0]),
        .opt_disable_o(cpu_optim_control_o)
    );

    // Constant status fields sit in flops to keep the outputs registered
    logic debug_state_ff;
    logic bytecode_ff;
    logic [MODE_W-1:0] exec_mode_ff;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            debug_state_ff <= 1'b1;
            bytecode_ff <= 1'b0;
            exec_mode_ff <= MODE_EXCEPTION;
        end else begin
            debug_state_ff <= 1'b1;
            bytecode_ff <= 1'b0;
            exec_mode_ff <= MODE_EXCEPTION;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = 1'b0;
    assign cpu_ack_o = cpu_ack_ff;
    assign cpu_rdata_o = cpu_rdata_ff;
    assign sr_force_o = sr_force_ff;
    assign debug_state_bit_o = debug_state_ff;
    assign bytecode_mode_bit_o = bytecode_ff;
    assign exec_mode_field_o = exec_mode_ff;
    assign bp_trigger_o = bp_trigger_ff;
    assign step_halt_o = step_halt_ff;
endmodule // drwg_top

//--- verilog/drwg_pkg.sv
/*
 * Constants of the debug register write guard: indices, fields, resets.
 * Assumes 32-bit words at word-aligned byte addresses.
 */
package drwg_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned IDX_W = 5;
    localparam int unsigned NREG = 23;
    localparam int unsigned ADDR_W = 12;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_DEV_CTRL = 5'h00;
    localparam logic [IDX_W-1:0] IDX_MEM_ACC_CS = 5'h01;
    localparam logic [IDX_W-1:0] IDX_MEM_ACC_ADDR = 5'h02;
    localparam logic [IDX_W-1:0] IDX_MEM_ACC_DATA = 5'h03;
    localparam logic [IDX_W-1:0] IDX_WATCH_TRIG = 5'h04;
    localparam logic [IDX_W-1:0] IDX_TRACE_CTRL = 5'h05;
    localparam logic [IDX_W-1:0] IDX_TRACE_START0 = 5'h06;
    localparam logic [IDX_W-1:0] IDX_TRACE_START1 = 5'h07;
    localparam logic [IDX_W-1:0] IDX_TRACE_END0 = 5'h08;
    localparam logic [IDX_W-1:0] IDX_TRACE_END1 = 5'h09;
    localparam logic [IDX_W-1:0] IDX_BW_CTRL_PC = 5'h0A;
    localparam logic [IDX_W-1:0] IDX_BW_CTRL_DATA = 5'h0B;
    localparam logic [IDX_W-1:0] IDX_BW_ADDR_PC = 5'h0C;
    localparam logic [IDX_W-1:0] IDX_BW_ADDR_DATA = 5'h0D;
    localparam logic [IDX_W-1:0] IDX_BW_DATA = 5'h0E;
    localparam logic [IDX_W-1:0] IDX_PROC_IDENT = 5'h0F;
    localparam logic [IDX_W-1:0] IDX_OPTIM_CTRL = 5'h10;
    localparam logic [IDX_W-1:0] IDX_EVENT_PAIR = 5'h11;
    localparam logic [IDX_W-1:0] IDX_DEBUG_INSN = 5'h12;
    localparam logic [IDX_W-1:0] IDX_DEBUG_PC = 5'h13;
    localparam logic [IDX_W-1:0] IDX_MBOX_TO_DBG = 5'h14;
    localparam logic [IDX_W-1:0] IDX_MBOX_TO_CPU = 5'h15;
    localparam logic [IDX_W-1:0] IDX_OVERRIDE_MASK = 5'h16;

    // Development control fields
    localparam int unsigned DC_OCD_EN = 0;
    localparam int unsigned DC_PTRACE_EN = 1;
    localparam int unsigned DC_PROT_LO = 2;
    localparam int unsigned DC_PROT_W = 2;
    localparam logic [1:0] PROT_ALL_PRIV = 2'h0;
    localparam logic [1:0] PROT_EXC_ONLY = 2'h1;

    // Enable bits a debugger may change while the CPU runs
    localparam logic [DATA_W-1:0] TRACE_EN_MASK = 32'h0000_0003;
    localparam logic [DATA_W-1:0] BW_EN_MASK = 32'h0000_003F;

    // Override mask bits
    localparam int unsigned OM_BR_PREDICT = 0;
    localparam int unsigned OM_BR_FOLD = 1;
    localparam int unsigned OM_RET_STACK = 2;
    localparam int unsigned OM_IMPR_BREAK = 3;
    localparam int unsigned OM_IMPR_EXEC = 4;
    localparam int unsigned OPT_W = 5;

    // Status values forced on debug entry from bytecode
    localparam int unsigned MODE_W = 3;
    localparam logic [MODE_W-1:0] MODE_EXCEPTION = 3'h6;
    localparam logic [MODE_W-1:0] MODE_APPLICATION = 3'h0;

    localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
endpackage

//--- verilog/drwg_permit.sv
/*
 * Write permission decode for one source and one register index.
 * Assumes state inputs of the same cycle.
 */
`timescale 1ns/10ps
module drwg_permit
    import drwg_pkg::*;
(
    // Request
    input wire logic [drwg_pkg::IDX_W-1:0] idx_i,
    input wire logic from_dbg_i,
    // State
    input wire logic ocd_en_i,
    input wire logic halted_i,
    input wire logic dm_bit_i,
    input wire logic prot_ok_i,
    input wire logic [1:0] trace_ch_en_i,
    input wire logic pc_bp_en_i,
    input wire logic data_bp_en_i,
    // Verdict
    output logic allow_o,
    output logic en_only_o
);
    logic full_access;
    logic unit_off;
    logic dbg_allow;
    logic cpu_allow;
    logic dbg_en_only;

    assign full_access = !ocd_en_i || halted_i;

    assign unit_off = (idx_i == IDX_TRACE_START0 || idx_i == IDX_TRACE_END0) ? !trace_ch_en_i[0] :
                      (idx_i == IDX_TRACE_START1 || idx_i == IDX_TRACE_END1) ? !trace_ch_en_i[1] :
                      (idx_i == IDX_BW_ADDR_PC) ? !pc_bp_en_i :
                      (idx_i == IDX_BW_ADDR_DATA || idx_i == IDX_BW_DATA) ? !data_bp_en_i :
                      (idx_i == IDX_EVENT_PAIR) ? !(pc_bp_en_i || data_bp_en_i) : 1'b1;

    // Debugger rights while the CPU runs or sits in monitor mode
    always_comb begin
        dbg_allow = 1'b0;
        dbg_en_only = 1'b0;
        if (idx_i == IDX_DEV_CTRL || idx_i == IDX_WATCH_TRIG || idx_i == IDX_PROC_IDENT ||
            idx_i == IDX_MBOX_TO_DBG || idx_i == IDX_MBOX_TO_CPU ||
            idx_i == IDX_OVERRIDE_MASK) begin
            dbg_allow = 1'b1;
        end else if (idx_i == IDX_MEM_ACC_CS || idx_i == IDX_MEM_ACC_ADDR ||
                     idx_i == IDX_MEM_ACC_DATA) begin
            dbg_allow = 1'b1;
        end else if (idx_i == IDX_TRACE_CTRL) begin
            dbg_allow = 1'b1;
            dbg_en_only = 1'b1;
        end else if (idx_i == IDX_BW_CTRL_PC || idx_i == IDX_BW_CTRL_DATA) begin
            dbg_allow = 1'b1;
            dbg_en_only = 1'b1;
        end else if (idx_i >= IDX_TRACE_START0 && idx_i <= IDX_TRACE_END1) begin
            dbg_allow = unit_off;
        end else if (idx_i == IDX_BW_ADDR_PC || idx_i == IDX_BW_ADDR_DATA ||
                     idx_i == IDX_BW_DATA || idx_i == IDX_EVENT_PAIR) begin
            dbg_allow = unit_off;
        end
    end

    // Monitor program rights; protect setting narrows them to two registers
    always_comb begin
        cpu_allow = 1'b0;
        if (idx_i == IDX_PROC_IDENT || idx_i == IDX_MBOX_TO_DBG) begin
            cpu_allow = 1'b1;
        end else if (!prot_ok_i) begin
            cpu_allow = 1'b0;
        end else if (halted_i || !ocd_en_i) begin
            cpu_allow = !(idx_i == IDX_OPTIM_CTRL || idx_i == IDX_DEBUG_INSN ||
                          idx_i == IDX_DEBUG_PC) || halted_i;
        end else if (idx_i == IDX_DEV_CTRL || idx_i == IDX_WATCH_TRIG ||
                     idx_i == IDX_MBOX_TO_CPU || idx_i == IDX_TRACE_CTRL) begin
            cpu_allow = 1'b1;
        end else if (idx_i >= IDX_TRACE_START0 && idx_i <= IDX_TRACE_END1) begin
            cpu_allow = 1'b1;
        end else if (idx_i == IDX_BW_CTRL_PC || idx_i == IDX_BW_CTRL_DATA) begin
            cpu_allow = dm_bit_i;
        end else if (idx_i == IDX_BW_ADDR_PC || idx_i == IDX_BW_ADDR_DATA ||
                     idx_i == IDX_BW_DATA || idx_i == IDX_EVENT_PAIR) begin
            cpu_allow = dm_bit_i || unit_off;
        end
    end

    // Optimisation, debug instruction and debug PC stay locked unless halted, or for the debugger unless OCD is off
    assign allow_o = idx_i >= IDX_W'(NREG) ? 1'b0 :
                     from_dbg_i ? (full_access || dbg_allow) : cpu_allow;
    assign en_only_o = from_dbg_i && !full_access && dbg_en_only;
endmodule // drwg_permit

//--- verilog/drwg_optim.sv
/*
 * Automatic disabling of CPU optimisations from the enabled debug features,
 * released per feature by the override mask. Registered outputs.
 * Assumes all inputs are synchronous to clk_i.
 */
`timescale 1ns/10ps
module drwg_optim
    import drwg_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Debug feature state
    input wire logic ocd_en_i,
    input wire logic ptrace_en_i,
    input wire logic data_bp_en_i,
    input wire logic [drwg_pkg::OPT_W-1:0] mask_i,
    // Disable controls to the CPU
    output logic [drwg_pkg::OPT_W-1:0] opt_disable_o
);
    logic [OPT_W-1:0] opt_disable_ff;
    logic [OPT_W-1:0] nxt_opt_disable;

    always_comb begin
        nxt_opt_disable[OM_BR_PREDICT] = ocd_en_i && ptrace_en_i && !mask_i[OM_BR_PREDICT];
        nxt_opt_disable[OM_BR_FOLD] = ocd_en_i && !mask_i[OM_BR_FOLD];
        nxt_opt_disable[OM_RET_STACK] = ocd_en_i && ptrace_en_i && !mask_i[OM_RET_STACK];
        nxt_opt_disable[OM_IMPR_BREAK] = ocd_en_i && !mask_i[OM_IMPR_BREAK];
        nxt_opt_disable[OM_IMPR_EXEC] = ocd_en_i && data_bp_en_i && !mask_i[OM_IMPR_EXEC];
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            opt_disable_ff <= '0;
        end else begin
            opt_disable_ff <= nxt_opt_disable;
        end
    end

    assign opt_disable_o = opt_disable_ff;
endmodule // drwg_optim

//--- sim/drwg_asserts.sv
/* Port assertions for the debug register write guard.
   Bound to drwg_top below; sees only its ports. */
`timescale 1ns/10ps
module drwg_asserts
    import drwg_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Move port
    input wire logic cpu_req_i,
    input wire logic cpu_ack_o,
    // Status override and breakpoints
    input wire logic debug_entry_i,
    input wire logic bytecode_mode_bit_i,
    input wire logic sr_force_o,
    input wire logic debug_state_bit_o,
    input wire logic bytecode_mode_bit_o,
    input wire logic [drwg_pkg::MODE_W-1:0] exec_mode_field_o,
    input wire logic bp_hit_raw_i,
    input wire logic bp_insn_is_stack_inc_i,
    input wire logic bp_trigger_o,
    // Single step
    input wire logic step_req_i,
    input wire logic retire_i,
    input wire logic retire_is_stack_inc_i,
    input wire logic step_halt_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_risc_ctx;
        sr_force_o && debug_state_bit_o && !bytecode_mode_bit_o &&
            exec_mode_field_o == MODE_EXCEPTION;
    endsequence
    sequence s_step_over;
        step_req_i ##1 (retire_i && !retire_is_stack_inc_i && !step_req_i);
    endsequence
    property p_ready;
        s_setup |=> pready;
    endproperty
    property p_ready_only;
        !(psel && !penable) |=> !pready;
    endproperty
    property p_no_err;
        pready |-> !pslverr;
    endproperty
    property p_ack;
        cpu_req_i |=> cpu_ack_o;
    endproperty
    property p_no_ack;
        !cpu_req_i |=> !cpu_ack_o;
    endproperty
    property p_force;
        debug_entry_i && bytecode_mode_bit_i |=> s_risc_ctx;
    endproperty
    property p_no_force;
        !(debug_entry_i && bytecode_mode_bit_i) |=> !sr_force_o;
    endproperty
    property p_bp_mask;
        bp_hit_raw_i && bp_insn_is_stack_inc_i |=> !bp_trigger_o;
    endproperty
    property p_bp_pass;
        bp_hit_raw_i && !bp_insn_is_stack_inc_i |=> bp_trigger_o;
    endproperty
    property p_step;
        s_step_over |=> step_halt_o;
    endproperty
    a_ready: assert property (p_ready) else $error("pready late");
    a_ready_only: assert property (p_ready_only) else $error("stray pready");
    a_no_err: assert property (p_no_err) else $error("pslverr raised");
    a_ack: assert property (p_ack) else $error("move not acked");
    a_no_ack: assert property (p_no_ack) else $error("stray ack");
    a_force: assert property (p_force) else $error("status not forced");
    a_no_force: assert property (p_no_force) else $error("stray force");
    a_bp_mask: assert property (p_bp_mask) else $error("break on stack inc");
    a_bp_pass: assert property (p_bp_pass) else $error("break lost");
    a_step: assert property (p_step) else $error("step did not halt");
endmodule // drwg_asserts
bind drwg_top drwg_asserts drwg_asserts_i (.*);

//--- sim/drwg_cpu_model.sv
/* Monitor-side CPU model: move requests and the bytecode bit.
   Assumes commands change just after a rising edge. */
`timescale 1ns/10ps
module drwg_cpu_model
    import drwg_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Commands from the bench
    input wire logic go_i,
    input wire logic we_i,
    input wire logic [drwg_pkg::IDX_W-1:0] idx_i,
    input wire logic [drwg_pkg::DATA_W-1:0] d_i,
    input wire logic bc_set_i,
    input wire logic sr_force_i,
    // Move port and status
    output logic req_o,
    output logic we_o,
    output logic [drwg_pkg::IDX_W-1:0] idx_o,
    output logic [drwg_pkg::DATA_W-1:0] d_o,
    output logic bc_o
);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_o <= 1'b0;
            bc_o <= 1'b0;
        end else begin
            req_o <= go_i;
            // Forced entry clears the bit, winning over a set
            bc_o <= sr_force_i ? 1'b0 : (bc_set_i | bc_o);
        end
    end
    // Idle lines toggle to catch off-request sampling
    always_ff @(posedge clk_i) begin
        we_o <= go_i ? we_i : ~we_o;
        idx_o <= go_i ? idx_i : ~idx_o;
        d_o <= go_i ? d_i : ~d_o;
    end
endmodule // drwg_cpu_model

//--- sim/drwg_top_tb.sv
/* Self-checking bench for the debug register write guard.
   Expected reads queue for a monitor process. */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module drwg_top_tb;
    import drwg_pkg::*;
    logic clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [ADDR_W-1:0] paddr = 0;
    logic [DATA_W-1:0] pwdata = 0, prdata, cpu_wdata_i, cpu_rdata_o, wd = 0;
    logic cpu_req_i, cpu_we_i, cpu_ack_o, go = 0, we = 0, bc_set = 0;
    logic [IDX_W-1:0] cpu_idx_i, idx = 0;
    logic cpu_halted_i = 0, cpu_privileged_i = 1, debug_mode_status_bit_i = 0;
    logic [MODE_W-1:0] cpu_exec_mode_i = 0, exec_mode_field_o;
    logic bytecode_mode_bit_i, debug_entry_i = 0, sr_force_o, debug_state_bit_o;
    logic bytecode_mode_bit_o, bp_hit_raw_i = 0, bp_insn_is_stack_inc_i = 0, step_req_i = 0;
    logic retire_i = 0, retire_is_stack_inc_i = 0, bp_trigger_o, step_halt_o;
    logic [OPT_W-1:0] cpu_optim_control_o;
    logic [DATA_W-1:0] aq[$];
    logic [DATA_W:0] cq[$];
    logic [DATA_W:0] c;
    int n_fail = 0, samples_checked = 0, seed = 33822;
    drwg_top drwg_top_i (.*);
    drwg_cpu_model drwg_cpu_model_i (.clk_i, .rst_i, .go_i(go), .we_i(we), .idx_i(idx),
        .d_i(wd), .bc_set_i(bc_set), .sr_force_i(sr_force_o), .req_o(cpu_req_i),
        .we_o(cpu_we_i), .idx_o(cpu_idx_i), .d_o(cpu_wdata_i), .bc_o(bytecode_mode_bit_i));
    initial forever #5 clk_i = ~clk_i;
    task automatic report_and_stop;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // A read carries its expected word in d
    task automatic apb(input logic w, input int i, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ADDR_W'(i * 4);
        pwdata <= d;
        if (!w) aq.push_back(d);
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i iff pready === 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic mv(input logic w, input int i, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        go <= 1'b1;
        we <= w;
        idx <= IDX_W'(i);
        wd <= d;
        cq.push_back({!w, d});
        @(posedge clk_i);
        go <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic wr(input logic cpu, input int i, input logic [DATA_W-1:0] d, e);
        if (cpu) mv(1, i, d);
        else apb(1, i, d);
        apb(0, i, e);
    endtask
    always @(posedge clk_i) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            c = aq.pop_front();
            `CHK("prdata", c[DATA_W-1:0], prdata)
        end
        if (cpu_ack_o === 1'b1) begin
            c = cq.pop_front();
            if (c[DATA_W]) `CHK("cpu_rdata_o", c[DATA_W-1:0], cpu_rdata_o)
        end
    end
    initial begin
        #300000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 24; i++) apb(0, i, REG_RESET);
        wr(0, 23, 32'hFFFF_FFFF, 32'h0);
        wr(0, IDX_DEBUG_INSN, 32'hA5A5_0001, 32'hA5A5_0001);
        apb(1, IDX_DEV_CTRL, 32'h1);
        wr(0, IDX_DEBUG_INSN, 32'h1234, 32'hA5A5_0001);
        wr(1, IDX_OPTIM_CTRL, 32'h66, 32'h0);
        apb(1, IDX_MEM_ACC_ADDR, 32'hABC);
        mv(1, IDX_MEM_ACC_ADDR, 32'h55);
        mv(0, IDX_MEM_ACC_ADDR, 32'hABC);
        wr(1, IDX_PROC_IDENT, 32'h77, 32'h77);
        wr(0, IDX_TRACE_CTRL, 32'hFFFF_FFFF, TRACE_EN_MASK);
        apb(1, IDX_TRACE_CTRL, 32'h1);
        wr(0, IDX_TRACE_START0, 32'h100, 32'h0);
        wr(0, IDX_TRACE_END1, 32'h200, 32'h200);
        wr(1, IDX_TRACE_START0, 32'h300, 32'h300);
        apb(1, IDX_BW_CTRL_PC, 32'hFFFF_FFFF);
        wr(1, IDX_BW_CTRL_PC, 32'h5, BW_EN_MASK);
        debug_mode_status_bit_i <= 1'b1;
        wr(1, IDX_BW_CTRL_PC, 32'h5, 32'h5);
        debug_mode_status_bit_i <= 1'b0;
        wr(0, IDX_BW_ADDR_PC, 32'h40, 32'h0);
        wr(0, IDX_BW_ADDR_DATA, 32'h50, 32'h50);
        apb(1, IDX_DEV_CTRL, 32'h9);
        wr(1, IDX_PROC_IDENT, 32'h88, 32'h88);
        wr(1, IDX_MBOX_TO_DBG, 32'h99, 32'h99);
        wr(1, IDX_MBOX_TO_CPU, 32'h11, 32'h0);
        cpu_privileged_i <= 1'b0;
        mv(0, IDX_PROC_IDENT, 32'h0);
        cpu_privileged_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        `CHK("optim", 5'h0A, cpu_optim_control_o)
        apb(1, IDX_OVERRIDE_MASK, 32'h2);
        repeat (3) @(posedge clk_i);
        `CHK("optim", 5'h08, cpu_optim_control_o)
        apb(1, IDX_DEV_CTRL, 32'h3);
        repeat (3) @(posedge clk_i);
        `CHK("optim", 5'h0D, cpu_optim_control_o)
        apb(0, IDX_OVERRIDE_MASK, 32'h2);
        cpu_halted_i <= 1'b1;
        wr(0, IDX_DEBUG_INSN, 32'h5A, 32'h5A);
        wr(0, IDX_DEBUG_PC, 32'h42, 32'h42);
        cpu_halted_i <= 1'b0;
        repeat (400) @(posedge clk_i) begin
            bp_hit_raw_i <= 1'($random(seed));
            bp_insn_is_stack_inc_i <= 1'($random(seed));
            debug_entry_i <= 1'($random(seed));
            bc_set <= 1'($random(seed));
            step_req_i <= 1'($random(seed));
            retire_i <= 1'($random(seed));
            retire_is_stack_inc_i <= 1'($random(seed));
        end
        report_and_stop();
    end
endmodule // drwg_top_tb
